// *** common/hdm_pkg.sv ***
// Shared constants for the haptic drive monitor readback block.
// Assumes a 10 MHz core clock and an 8-bit register port behind the serial bus.
package hdm_pkg;

   // Register map
   localparam logic [7:0] SUPPLY_MONITOR_ADDR  = 8'h21;
   localparam logic [7:0] PERIOD_READOUT_ADDR  = 8'h22;
   localparam logic [7:0] SUPPLY_MONITOR_RESET = 8'h00;
   localparam logic [7:0] PERIOD_READOUT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;
   localparam logic [7:0] CODE_MAX             = 8'hFF;
   localparam logic [7:0] CODE_ONE             = 8'h01;

   // Supply code scaling: volts = code * 5.6 V / 255
   localparam int SUPPLY_FULL_SCALE_MV = 5600;
   localparam int SUPPLY_CODE_SPAN     = 255;

   // Period code scaling: one code step is 98.46 us
   localparam int CLOCK_PERIOD_PS = 100000;
   localparam int PERIOD_STEP_PS  = 98460000;
   // Half a period step in cycles, rounded down; counting half steps over
   // one back-EMF half cycle yields the full-period code directly.
   localparam int HALF_STEP_CYCLES_INT = PERIOD_STEP_PS / (2 * CLOCK_PERIOD_PS);
   localparam logic [15:0] HALF_STEP_CYCLES = 16'(HALF_STEP_CYCLES_INT);
   localparam logic [15:0] COUNT_ONE        = 16'h0001;

endpackage

// *** core/hdm_tick_gen.sv ***
// Free-running tick divider: one-cycle tick every reload cycles while run is high.
// Assumes reload is at least one; the count restarts whenever run drops.
`timescale 1ns/10ps
`default_nettype none
module hdm_tick_gen (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Control
   input  wire logic        run,
   input  wire logic [15:0] reload,
   // Output
   output logic             tick
);

   typedef struct packed {
      logic [15:0] count;
      logic        tick;
   } hdm_tick_t;

   hdm_tick_t state_reg;
   hdm_tick_t state_next;

   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (!run) begin
         state_next.count = '0;
      end else if (state_reg.count >= (reload - hdm_pkg::COUNT_ONE)) begin
         state_next.count = '0;
         state_next.tick = 1'b1;
      end else begin
         state_next.count = state_reg.count + hdm_pkg::COUNT_ONE;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign tick = state_reg.tick;

endmodule
`default_nettype wire

// *** core/hdm_edge_track.sv ***
// Back-EMF zero-crossing detector: pulses once per sign change while run is high.
// Assumes the comparator level is already synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module hdm_edge_track (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // Sense
   input  wire logic run,
   input  wire logic level,
   // Output
   output logic      crossing
);

   typedef struct packed {
      logic prev;
      logic primed;
      logic crossing;
   } hdm_edge_t;

   hdm_edge_t state_reg;
   hdm_edge_t state_next;

   always_comb begin
      state_next = state_reg;
      state_next.crossing = 1'b0;
      state_next.prev = level;
      if (!run) begin
         // Unprimed so the first sample after drive start is no crossing
         state_next.primed = 1'b0;
      end else begin
         state_next.crossing = state_reg.primed && (level != state_reg.prev);
         state_next.primed = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign crossing = state_reg.crossing;

endmodule
`default_nettype wire

// *** core/hdm_readback.sv ***
// Haptic drive monitor readback: supply and resonance-period codes,
// auto-resonance tracking and differential drive polarity.
// Assumes a register port from the serial-bus front end and synchronous sense inputs.
//
// How it works
// (RQ1) Supply code refreshes from each sample taken during drive; volts equal code times 5.6 over 255.
// (RQ2) Supply code only takes new samples while a waveform is being driven.
// (RQ3) Resonance-period code is measured only while a waveform is being driven.
// (RQ4) Each period code step stands for 98.46 microseconds of resonance period.
// (RQ5) Both codes reset to zero and are host readable and writable.
// (RQ6) Tracking locks to resonance after half a drive cycle.
// (RQ7) Tracking re-evaluates the frequency on every drive half cycle.
// (RQ8) Resonance is derived from back-EMF zero crossings sensed during drive.
// (RQ9) Tracking needs no calibration and ignores level calibration entirely.
// (RQ10) Rotating-mass drive direction is set by output pair polarity, reverse brakes.
// (RQ11) Fixed-frequency select drives at the chosen rate, tracking is bypassed.
// (RQ12) Codes hold their last values while no waveform is driven.
`timescale 1ns/10ps
`default_nettype none
module hdm_readback (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Register port
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [7:0]  regWriteData,
   output logic      [7:0]  regReadData,
   output logic             regReadValid,
   // Drive control
   input  wire logic        driveActive,
   input  wire logic        actuatorIsLinear,
   input  wire logic        linearActuatorFixedFrequencySelect,
   input  wire logic [15:0] fixedHalfCycles,
   input  wire logic        reverseDrive,
   // Sense
   input  wire logic        bemfPositive,
   input  wire logic [7:0]  supplySample,
   input  wire logic        supplySampleValid,
   // Drive outputs
   output logic             drivePos,
   output logic             driveNeg,
   // Status
   output logic [7:0]       supplyCode,
   output logic [7:0]       periodCode,
   output logic             periodLocked
);

   typedef enum logic [1:0] {
      TRK_IDLE,
      TRK_WAIT_EDGE,
      TRK_MEASURE
   } hdm_trk_t;

   typedef struct packed {
      hdm_trk_t   trk;
      logic [7:0] halfCount;
      logic [7:0] supplyCode;
      logic [7:0] periodCode;
      logic       locked;
      logic       polarity;
      logic       drivePos;
      logic       driveNeg;
      logic [7:0] readData;
      logic       readValid;
   } hdm_main_t;

   hdm_main_t state_reg;
   hdm_main_t state_next;

   logic closedLoop;
   logic fixedLoop;
   logic bemfCrossing;
   logic halfStepTick;
   logic fixedTick;
   logic halfStepRun;

   // Closed loop only for a linear actuator with fixed frequency off
   assign closedLoop = driveActive && actuatorIsLinear && !linearActuatorFixedFrequencySelect; // [RQ11]
   assign fixedLoop  = driveActive && actuatorIsLinear && linearActuatorFixedFrequencySelect;  // [RQ11]

   // Half-step timer restarts on each crossing so each half cycle counts from zero
   assign halfStepRun = (state_reg.trk == TRK_MEASURE) && !bemfCrossing;

   hdm_edge_track u_bemf_edge (
      .clock    (clock),
      .reset_n  (reset_n),
      .run      (closedLoop),
      .level    (bemfPositive),
      .crossing (bemfCrossing)
   );

   hdm_tick_gen u_half_step (
      .clock   (clock),
      .reset_n (reset_n),
      .run     (halfStepRun),
      .reload  (hdm_pkg::HALF_STEP_CYCLES),
      .tick    (halfStepTick)
   );

   hdm_tick_gen u_fixed_rate (
      .clock   (clock),
      .reset_n (reset_n),
      .run     (fixedLoop),
      .reload  (fixedHalfCycles),
      .tick    (fixedTick)
   );

   always_comb begin
      state_next = state_reg;
      state_next.readValid = 1'b0;

      // Host writes land first; a same-cycle measurement overrides them
      if (regWrite) begin
         if (regAddr == hdm_pkg::SUPPLY_MONITOR_ADDR) begin
            state_next.supplyCode = regWriteData; // [RQ5]
         end
         if (regAddr == hdm_pkg::PERIOD_READOUT_ADDR) begin
            state_next.periodCode = regWriteData; // [RQ5]
         end
      end

      // Supply samples accepted only during playback, held otherwise
      if (driveActive && supplySampleValid) begin
         state_next.supplyCode = supplySample; // [RQ1] [RQ2] [RQ12]
      end

      // Tracking is driven purely by back-EMF crossings; no calibration state gates it
      case (state_reg.trk) // [RQ8] [RQ9]
         TRK_IDLE: begin
            state_next.halfCount = '0;
            state_next.locked = 1'b0;
            if (closedLoop) begin
               state_next.trk = TRK_WAIT_EDGE;
            end
         end
         TRK_WAIT_EDGE: begin
            if (!closedLoop) begin
               state_next.trk = TRK_IDLE;
            end else if (bemfCrossing) begin
               state_next.halfCount = '0;
               state_next.trk = TRK_MEASURE;
            end
         end
         TRK_MEASURE: begin
            if (!closedLoop) begin
               // Period code keeps the last measurement
               state_next.trk = TRK_IDLE; // [RQ12]
            end else if (bemfCrossing) begin
               // Half a cycle of half steps is the full period in steps
               state_next.periodCode = state_reg.halfCount; // [RQ3] [RQ4] [RQ6] [RQ7]
               state_next.locked = 1'b1; // [RQ6]
               state_next.halfCount = '0;
            end else if (halfStepTick && (state_reg.halfCount != hdm_pkg::CODE_MAX)) begin
               // Saturates on very slow actuators instead of wrapping
               state_next.halfCount = state_reg.halfCount + hdm_pkg::CODE_ONE; // [RQ4]
            end
         end
         default: begin
            state_next.trk = TRK_IDLE;
         end
      endcase

      // Differential output polarity
      if (!driveActive) begin
         state_next.polarity = 1'b0;
         state_next.drivePos = 1'b0;
         state_next.driveNeg = 1'b0;
      end else if (!actuatorIsLinear) begin
         // Reverse polarity spins the mass backwards, used for braking
         state_next.drivePos = !reverseDrive; // [RQ10]
         state_next.driveNeg = reverseDrive;  // [RQ10]
      end else begin
         if (linearActuatorFixedFrequencySelect) begin
            if (fixedTick) begin
               state_next.polarity = !state_reg.polarity; // [RQ11]
            end
         end else if (bemfCrossing) begin
            // Commutate at each back-EMF crossing to sit on resonance
            state_next.polarity = !state_reg.polarity; // [RQ7] [RQ8]
         end
         state_next.drivePos = !state_next.polarity;
         state_next.driveNeg = state_next.polarity;
      end

      // Register read answer, one cycle after the strobe
      if (regRead) begin
         state_next.readValid = 1'b1;
         case (regAddr)
            hdm_pkg::SUPPLY_MONITOR_ADDR: state_next.readData = state_reg.supplyCode;
            hdm_pkg::PERIOD_READOUT_ADDR: state_next.readData = state_reg.periodCode;
            default:                      state_next.readData = hdm_pkg::UNMAPPED_READ_VALUE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg.trk        <= TRK_IDLE;
         state_reg.halfCount  <= '0;
         state_reg.supplyCode <= hdm_pkg::SUPPLY_MONITOR_RESET; // [RQ5]
         state_reg.periodCode <= hdm_pkg::PERIOD_READOUT_RESET; // [RQ5]
         state_reg.locked     <= 1'b0;
         state_reg.polarity   <= 1'b0;
         state_reg.drivePos   <= 1'b0;
         state_reg.driveNeg   <= 1'b0;
         state_reg.readData   <= hdm_pkg::UNMAPPED_READ_VALUE;
         state_reg.readValid  <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign regReadData  = state_reg.readData;
   assign regReadValid = state_reg.readValid;
   assign drivePos     = state_reg.drivePos;
   assign driveNeg     = state_reg.driveNeg;
   assign supplyCode   = state_reg.supplyCode;
   assign periodCode   = state_reg.periodCode;
   assign periodLocked = state_reg.locked;

endmodule
`default_nettype wire

// *** verif/hdm_readback_checker.sv ***
// Port-level concurrent checks for the readback block.
// Assumes one clock domain; bound onto every hdm_readback instance.
`timescale 1ns/10ps
`default_nettype none
module hdm_readback_checker (
   // Clock and reset
   input wire logic       clock,
   input wire logic       reset_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [7:0] regReadData,
   input wire logic       regReadValid,
   // Drive and sense
   input wire logic       driveActive,
   input wire logic       actuatorIsLinear,
   input wire logic       linearActuatorFixedFrequencySelect,
   input wire logic       reverseDrive,
   input wire logic [7:0] supplySample,
   input wire logic       supplySampleValid,
   // Watched outputs
   input wire logic       drivePos,
   input wire logic       driveNeg,
   input wire logic [7:0] supplyCode,
   input wire logic [7:0] periodCode,
   input wire logic       periodLocked
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   wire logic wrSupply = regWrite && regAddr == hdm_pkg::SUPPLY_MONITOR_ADDR;
   wire logic wrPeriod = regWrite && regAddr == hdm_pkg::PERIOD_READOUT_ADDR;
   wire logic fixedOn  = driveActive && actuatorIsLinear && linearActuatorFixedFrequencySelect;
   wire logic mapped   = wrSupply || wrPeriod || regAddr == 8'h21 || regAddr == 8'h22;
   // Three idle cycles let a capture already in flight land first
   sequence idleThree; !driveActive [*3]; endsequence
   sequence fixedThree; fixedOn [*3]; endsequence
   a_read_valid_pulse: assert property (1'b1 |=> regReadValid == $past(regRead)) else $error("read valid");
   a_read_supply_data: assert property (regRead && regAddr == 8'h21 |=>
      regReadData == $past(supplyCode)) else $error("supply read data");
   a_read_period_data: assert property (regRead && regAddr == 8'h22 |=>
      regReadData == $past(periodCode)) else $error("period read data");
   a_unmapped_read_zero: assert property (regRead && !mapped |=> regReadData == 8'h00) else $error("unmapped");
   a_supply_sample_taken: assert property (driveActive && supplySampleValid |=>
      supplyCode == $past(supplySample)) else $error("supply sample");
   a_supply_idle_hold: assert property (!driveActive && !wrSupply |=> $stable(supplyCode)) else $error("supply held");
   a_period_idle_hold: assert property (idleThree ##0 !wrPeriod |=> $stable(periodCode)) else $error("period held");
   a_mass_drive_polarity: assert property (driveActive && !actuatorIsLinear |=>
      drivePos == !$past(reverseDrive) && driveNeg == $past(reverseDrive)) else $error("polarity");
   a_idle_outputs_off: assert property (!driveActive |=> !drivePos && !driveNeg) else $error("idle drive");
   a_fixed_no_lock: assert property (fixedThree |-> !periodLocked) else $error("fixed lock");
endmodule
bind hdm_readback hdm_readback_checker i_hdm_readback_checker (
   .clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .regReadValid(regReadValid), .driveActive(driveActive),
   .actuatorIsLinear(actuatorIsLinear), .linearActuatorFixedFrequencySelect(linearActuatorFixedFrequencySelect),
   .reverseDrive(reverseDrive), .supplySample(supplySample), .supplySampleValid(supplySampleValid),
   .drivePos(drivePos), .driveNeg(driveNeg), .supplyCode(supplyCode), .periodCode(periodCode),
   .periodLocked(periodLocked)
);
`default_nettype wire

// *** verif/hdm_host_model.sv ***
// Host register master standing in for the serial-bus front end.
// Assumes the bench calls its task; strobes move on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module hdm_host_model (
   // Clock
   input  wire logic  clock,
   // Register port
   output logic [7:0] regAddr,
   output logic       regWrite,
   output logic       regRead,
   output logic [7:0] regWriteData
);
   initial begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWriteData = 8'h00;
   end
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock);
      regAddr <= addr;
      regWriteData <= data;
      regWrite <= wr;
      regRead <= !wr;
      @(negedge clock);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      // Inverted idle values so stale address or data never looks valid
      regAddr <= ~addr;
      regWriteData <= ~data;
   endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for hdm_readback: registers, supply, tracking, drive.
// Assumes the host model owns the register port; bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int STEP = hdm_pkg::HALF_STEP_CYCLES_INT;
   logic clock, reset_n, driveActive, isLinear, fixedSel, reverseDrive, bemfPositive, supplyValid;
   logic [15:0] fixedHalf;
   logic [7:0] supplySample, s, n1, n2;
   logic p;
   wire logic [7:0] regAddr, regWriteData, regReadData, supplyCode, periodCode;
   wire logic regWrite, regRead, regReadValid, drivePos, driveNeg, periodLocked;
   logic [7:0] expQ[$];
   int nErrors = 0;
   int testsRun = 0;
   hdm_host_model i_hdm_host_model (.clock(clock), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWriteData(regWriteData));
   hdm_readback i_hdm_readback (.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
      .driveActive(driveActive), .actuatorIsLinear(isLinear), .linearActuatorFixedFrequencySelect(fixedSel),
      .fixedHalfCycles(fixedHalf), .reverseDrive(reverseDrive), .bemfPositive(bemfPositive),
      .supplySample(supplySample), .supplySampleValid(supplyValid), .drivePos(drivePos), .driveNeg(driveNeg),
      .supplyCode(supplyCode), .periodCode(periodCode), .periodLocked(periodLocked));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nErrors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic completeRun();
      // A read that never answered leaves its note behind
      if (expQ.size() != 0) begin
         nErrors++;
      end
      $display("Comparisons %0d, mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      expQ.push_back(exp);
      i_hdm_host_model.access(1'b0, addr, 8'h00);
   endtask
   // Toggle back-EMF sign n and a half steps later, then let the capture land
   task automatic halfStep(input int n);
      repeat (n * STEP + STEP / 2) @(negedge clock);
      bemfPositive = ~bemfPositive;
      repeat (3) @(negedge clock);
   endtask
   task automatic pulseSample(input logic [7:0] v);
      supplySample = v;
      supplyValid = 1'b1;
      @(negedge clock);
      supplyValid = 1'b0;
      @(negedge clock);
   endtask
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(negedge clock) begin
      if (regReadValid === 1'b1) begin
         if (expQ.size() == 0) begin
            nErrors++;
            $display("Error at %0t: unexpected read data %h", $time, regReadData);
         end else begin
            check(regReadData, expQ.pop_front());
         end
      end
   end
   initial begin
      #5000000;
      nErrors++;
      completeRun();
   end
   initial begin
      {reset_n, driveActive, isLinear, fixedSel, reverseDrive, bemfPositive, supplyValid} = 7'h00;
      fixedHalf = 16'h0005;
      supplySample = 8'h00;
      repeat (8) @(negedge clock);
      reset_n = 1'b1;
      void'($urandom(32876));
      rd(8'h21, 8'h00);
      rd(8'h22, 8'h00);
      rd(8'h23, 8'h00);
      s = 8'($urandom);
      i_hdm_host_model.access(1'b1, 8'h21, s);
      rd(8'h21, s);
      i_hdm_host_model.access(1'b1, 8'h22, ~s);
      rd(8'h22, ~s);
      driveActive = 1'b1;
      s = 8'($urandom);
      pulseSample(s);
      check(supplyCode, s);
      check({drivePos, driveNeg}, 8'h02);
      reverseDrive = 1'b1;
      repeat (2) @(negedge clock);
      check({drivePos, driveNeg}, 8'h01);
      rd(8'h21, s);
      driveActive = 1'b0;
      pulseSample(~s);
      check(supplyCode, s);
      check({drivePos, driveNeg}, 8'h00);
      n1 = 8'($urandom_range(4, 2));
      n2 = n1 + 8'h01;
      isLinear = 1'b1;
      fixedHalf = 16'($urandom_range(200, 1));
      driveActive = 1'b1;
      halfStep(int'(n1));
      halfStep(int'(n1));
      check(periodCode, n1);
      check(periodLocked, 8'h01);
      p = drivePos;
      halfStep(int'(n2));
      check(periodCode, n2);
      check(drivePos, {7'h00, ~p});
      driveActive = 1'b0;
      halfStep(1);
      check(periodCode, n2);
      rd(8'h22, n2);
      fixedSel = 1'b1;
      fixedHalf = 16'h0005;
      driveActive = 1'b1;
      repeat (3) @(negedge clock);
      p = drivePos;
      repeat (5) @(negedge clock);
      check(drivePos, {7'h00, ~p});
      halfStep(1);
      halfStep(1);
      check(periodCode, n2);
      check(periodLocked, 8'h00);
      driveActive = 1'b0;
      repeat (4) @(negedge clock);
      // Mid-run reset must clear both codes again
      reset_n = 1'b0;
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      check(supplyCode, 8'h00);
      check(periodCode, 8'h00);
      check(periodLocked, 8'h00);
      rd(8'h21, 8'h00);
      rd(8'h22, 8'h00);
      repeat (4) @(negedge clock);
      completeRun();
   end
endmodule
`default_nettype wire
